//--- src/iepsel_pkg.sv
// constants, register map and types for the enable gating and priority select block
package iepsel_pkg;

  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int NUM_IRQ  = 16;  // ids 0-3 soft, 4-7 private, 8-15 shared
  localparam int NUM_SGI  = 4;
  localparam int NUM_PRIV = 8;   // ids held in the redistributor
  localparam int ID_W     = 4;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int PRIO_W   = 8;

  // ---------------------------------------------------------------------
  // priority width: five implemented bits, 32 levels
  // ---------------------------------------------------------------------
  localparam logic [7:0] PRIO_IMPL_MASK = 8'hF8;
  localparam logic [2:0] PRIO_BITS_FIELD = 3'h4;  // implemented bits minus one
  localparam logic [7:0] PRIO_RESET     = 8'h00;
  localparam logic [7:0] PRIO_NS_TOP    = 8'h80;
  localparam logic [3:0] RESERVED_ID    = 4'hF;
  localparam logic [7:0] RESERVED_PRIO  = 8'hA0;  // fixed, read only
  localparam logic [7:0] PMR_RESET      = 8'h00;

  // ---------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_DIST_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DIST_SET    = 8'h04;
  localparam logic [7:0] OFS_DIST_CLR    = 8'h08;
  localparam logic [7:0] OFS_REDIST_SET  = 8'h0C;
  localparam logic [7:0] OFS_REDIST_CLR  = 8'h10;
  localparam logic [7:0] OFS_REDIST_CTRL = 8'h14;
  localparam logic [7:0] OFS_GROUP       = 8'h18;
  localparam logic [7:0] OFS_PEND_SET    = 8'h1C;
  localparam logic [7:0] OFS_PEND_CLR    = 8'h20;
  localparam logic [7:0] OFS_CPU_GRP     = 8'h24;
  localparam logic [7:0] OFS_PMR         = 8'h28;
  localparam logic [7:0] OFS_CPU_CTRL    = 8'h2C;
  localparam logic [7:0] OFS_LPI_STAT    = 8'h30;
  localparam logic [3:0] OFS_PRIO_PAGE   = 4'h4;  // 0x40-0x4F, four ids a word

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int BIT_GRP0      = 0;
  localparam int BIT_GRP1NS    = 1;
  localparam int BIT_GRP1S     = 2;
  localparam int BIT_LPI_EN    = 0;
  localparam int CTRL_ID_LSB   = 0;
  localparam int CTRL_FOUND    = 4;
  localparam int CTRL_PRI_LSB  = 8;

  // interrupt group of each id, two bits per id in the group register
  typedef enum logic [1:0] {
    GRP_ZERO   = 2'h0,
    GRP_ONE_NS = 2'h1,
    GRP_ONE_S  = 2'h2,
    GRP_NONE   = 2'h3
  } iepsel_grp_t;

endpackage : iepsel_pkg

//--- src/iepsel_top.sv
// enable gating, priority storage and highest pending select for one processing element
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module iepsel_top (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_sys_rst,
  // register port
  input  wire logic [iepsel_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [iepsel_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  input  wire logic                          i_nonsecure,
  output logic      [iepsel_pkg::DATA_W-1:0] o_rdata,
  // interrupt sources
  input  wire logic [iepsel_pkg::NUM_IRQ-1:iepsel_pkg::NUM_SGI] i_irq_line,
  input  wire logic                          i_lpi_set,
  // cpu interface side
  input  wire logic                          i_ack,
  output logic                               o_irq_valid,
  output logic      [iepsel_pkg::ID_W-1:0]   o_irq_id,
  output logic      [iepsel_pkg::PRIO_W-1:0] o_irq_prio,
  output logic      [1:0]                    o_irq_group,
  output logic                               o_retrieve,
  output logic                               o_release
);

  // -----------------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------------
  logic [2:0]                          dist_ctrl;     // group enables at distributor
  logic [2:0]                          cpu_grp;       // group enables at cpu interface
  logic [iepsel_pkg::NUM_IRQ-1:0]      enable;
  logic [iepsel_pkg::NUM_IRQ-1:0]      pending;
  logic [2*iepsel_pkg::NUM_IRQ-1:0]    group_cfg;
  logic [7:0]                          pmr;
  logic                                lpi_enable;
  logic                                lpi_pending;
  logic [iepsel_pkg::NUM_IRQ-1:iepsel_pkg::NUM_SGI] line_prev;
  logic [7:0]                          prio [iepsel_pkg::NUM_IRQ];

  logic [3:0]                          dist_en4;
  logic [3:0]                          cpu_en4;
  logic [iepsel_pkg::NUM_IRQ-1:0]      cand;
  logic [iepsel_pkg::NUM_IRQ-1:0]      rise;
  logic [7:0]                          prio_rd [iepsel_pkg::NUM_IRQ];
  logic [iepsel_pkg::NUM_IRQ-1:0]      prio_wr_ns;
  logic [iepsel_pkg::NUM_IRQ-1:0]      low_bits_set;
  logic                                best_found;
  logic [iepsel_pkg::ID_W-1:0]         best_id;
  logic [7:0]                          best_prio;
  logic [1:0]                          best_grp;
  logic                                sig_ok;
  logic [iepsel_pkg::DATA_W-1:0]       next_rdata;
  logic [iepsel_pkg::NUM_IRQ-1:0]      next_pending;
  logic                                dist_fall;
  logic                                cpu_fall;
  logic                                wr_dist;
  logic                                wr_cpu;

  // reserved group code maps onto an always-zero enable bit
  assign dist_en4 = {1'b0, dist_ctrl};
  assign cpu_en4  = {1'b0, cpu_grp};
  assign wr_dist  = i_wr && (i_addr == iepsel_pkg::OFS_DIST_CTRL);
  assign wr_cpu   = i_wr && (i_addr == iepsel_pkg::OFS_CPU_GRP);

  // -----------------------------------------------------------------------
  // group enables
  // -----------------------------------------------------------------------
  // three distributor bits and three cpu bits, secure and nonsecure group one apart
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dist_ctrl <= 3'h0;
      cpu_grp   <= 3'h0;
    end else begin
      if (wr_dist) begin
        dist_ctrl <= i_wdata[2:0];
      end
      if (wr_cpu) begin
        cpu_grp <= i_wdata[2:0];
      end
    end
  end

  // -----------------------------------------------------------------------
  // individual enables
  // -----------------------------------------------------------------------
  // ids 0-7 through redistributor index zero, shared ids through distributor index one
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      enable <= 16'h0000;
    end else if (i_wr) begin
      case (i_addr)
        iepsel_pkg::OFS_REDIST_SET: enable[7:0]  <= enable[7:0] | i_wdata[7:0];
        iepsel_pkg::OFS_REDIST_CLR: enable[7:0]  <= enable[7:0] & ~i_wdata[7:0];
        iepsel_pkg::OFS_DIST_SET:   enable[15:8] <= enable[15:8] | i_wdata[7:0];
        iepsel_pkg::OFS_DIST_CLR:   enable[15:8] <= enable[15:8] & ~i_wdata[7:0];
        default:                    enable       <= enable;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // group membership, mask, locality enable
  // -----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      group_cfg  <= 32'h0000_0000;
      pmr        <= iepsel_pkg::PMR_RESET;
      lpi_enable <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        iepsel_pkg::OFS_GROUP:       group_cfg  <= i_wdata;
        iepsel_pkg::OFS_PMR:         pmr        <= i_wdata[7:0];
        iepsel_pkg::OFS_REDIST_CTRL: lpi_enable <= i_wdata[iepsel_pkg::BIT_LPI_EN];
        default:                     pmr        <= pmr;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // pending state
  // -----------------------------------------------------------------------
  // edges pend whatever the enables say; sets win over same-cycle clears
  assign rise = {i_irq_line & ~line_prev, 4'h0};

  always_comb begin
    next_pending = pending;
    if (i_ack && o_irq_valid) begin
      next_pending[o_irq_id] = 1'b0;
    end
    if (i_wr && (i_addr == iepsel_pkg::OFS_PEND_CLR)) begin
      next_pending = next_pending & ~i_wdata[15:0];
    end
    next_pending = next_pending | rise;
    if (i_wr && (i_addr == iepsel_pkg::OFS_PEND_SET)) begin
      next_pending = next_pending | i_wdata[15:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pending   <= 16'h0000;
      line_prev <= 12'h000;
    end else begin
      pending   <= next_pending;
      line_prev <= i_irq_line;
    end
  end

  // locality interrupts only pend while enabled; write one clears, set wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lpi_pending <= 1'b0;
    end else if (i_lpi_set && lpi_enable) begin
      lpi_pending <= 1'b1;
    end else if (i_wr && (i_addr == iepsel_pkg::OFS_LPI_STAT) && i_wdata[0]) begin
      lpi_pending <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // priority fields, one generate entry per id
  // -----------------------------------------------------------------------
  // ids 0-7 are this element's redistributor copies; shared ids live in distributor
  for (genvar g = 0; g < iepsel_pkg::NUM_IRQ; g++) begin : g_prio
    localparam logic [1:0] WORD = 2'(g / 4);
    logic [7:0] wbyte;
    logic       hit;
    logic       ns_own;
    assign wbyte  = i_wdata[8*(g%4) +: 8];
    assign hit    = i_wr && (i_addr[7:4] == iepsel_pkg::OFS_PRIO_PAGE)
                    && (i_addr[3:2] == WORD);
    assign ns_own = (group_cfg[2*g +: 2] == iepsel_pkg::GRP_ONE_NS);
    assign prio_wr_ns[g]   = hit && i_nonsecure && ns_own;
    assign low_bits_set[g] = |(prio[g] & ~iepsel_pkg::PRIO_IMPL_MASK);

    // nonsecure sees its own ids shifted up one bit, spreading the lower urgency half over the whole range; other ids read zero
    always_comb begin
      if (!i_nonsecure) begin
        prio_rd[g] = prio[g];
      end else if (ns_own) begin
        prio_rd[g] = {prio[g][6:0], 1'b0};
      end else begin
        prio_rd[g] = 8'h00;
      end
    end

    if (g == int'(iepsel_pkg::RESERVED_ID)) begin : g_fixed
      // reserved shared id, priority cannot be changed
      assign prio[g] = iepsel_pkg::RESERVED_PRIO;
    end else begin : g_rw
      // only implemented bits are stored, so all ones reads back 0xF8
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          prio[g] <= iepsel_pkg::PRIO_RESET;
        end else if (hit && !i_nonsecure) begin
          prio[g] <= wbyte & iepsel_pkg::PRIO_IMPL_MASK;
        end else if (prio_wr_ns[g]) begin
          prio[g] <= (iepsel_pkg::PRIO_NS_TOP | {1'b0, wbyte[7:1]})
                     & iepsel_pkg::PRIO_IMPL_MASK;
        end
      end
    end

    // candidate needs pending, own enable and distributor group enable
    assign cand[g] = pending[g] && enable[g]
                     && dist_en4[group_cfg[2*g +: 2]];
  end

  // -----------------------------------------------------------------------
  // highest priority pending select
  // -----------------------------------------------------------------------
  // strict less-than keeps the lowest id on a tie, so the winner is stable
  always_comb begin
    best_found = 1'b0;
    best_id    = '0;
    best_prio  = 8'hFF;
    for (int i = 0; i < iepsel_pkg::NUM_IRQ; i++) begin
      if (cand[i] && (!best_found || (prio[i] < best_prio))) begin
        best_found = 1'b1;
        best_id    = 4'(i);
        best_prio  = prio[i];
      end
    end
  end

  // cpu-disabled winner is kept in the race: it masks but is not signaled
  assign best_grp = group_cfg[2*best_id +: 2];
  assign sig_ok   = best_found && cpu_en4[best_grp]
                    && (best_prio < pmr);

  // -----------------------------------------------------------------------
  // presentation to cpu interface
  // -----------------------------------------------------------------------
  // a write that drops the presented group's enable also yanks the interrupt back
  assign dist_fall = wr_dist && o_irq_valid && dist_en4[o_irq_group]
                     && !i_wdata[o_irq_group];
  assign cpu_fall  = wr_cpu && o_irq_valid && cpu_en4[o_irq_group]
                     && !i_wdata[o_irq_group];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq_valid <= 1'b0;
      o_irq_id    <= '0;
      o_irq_prio  <= 8'hFF;
      o_irq_group <= 2'h0;
      o_retrieve  <= 1'b0;
      o_release   <= 1'b0;
    end else begin
      o_irq_valid <= sig_ok;
      o_irq_id    <= best_id;
      o_irq_prio  <= best_prio;
      o_irq_group <= best_grp;
      o_retrieve  <= dist_fall;
      o_release   <= cpu_fall;
    end
  end

  // -----------------------------------------------------------------------
  // register read
  // -----------------------------------------------------------------------
  // data stands only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        iepsel_pkg::OFS_DIST_CTRL:   next_rdata[2:0] = dist_ctrl;
        iepsel_pkg::OFS_DIST_SET,
        iepsel_pkg::OFS_DIST_CLR:    next_rdata[7:0] = enable[15:8];
        iepsel_pkg::OFS_REDIST_SET,
        iepsel_pkg::OFS_REDIST_CLR:  next_rdata[7:0] = enable[7:0];
        iepsel_pkg::OFS_REDIST_CTRL: next_rdata[0]   = lpi_enable;
        iepsel_pkg::OFS_GROUP:       next_rdata      = group_cfg;
        iepsel_pkg::OFS_PEND_SET,
        iepsel_pkg::OFS_PEND_CLR:    next_rdata[15:0] = pending;
        iepsel_pkg::OFS_CPU_GRP:     next_rdata[2:0] = cpu_grp;
        iepsel_pkg::OFS_PMR:         next_rdata[7:0] = pmr;
        iepsel_pkg::OFS_CPU_CTRL: begin
          next_rdata[iepsel_pkg::CTRL_ID_LSB +: 4]  = best_id;
          next_rdata[iepsel_pkg::CTRL_FOUND]        = best_found;
          next_rdata[iepsel_pkg::CTRL_PRI_LSB +: 3] = iepsel_pkg::PRIO_BITS_FIELD;
        end
        iepsel_pkg::OFS_LPI_STAT:    next_rdata[0] = lpi_pending;
        default: begin
          if (i_addr[7:4] == iepsel_pkg::OFS_PRIO_PAGE) begin
            next_rdata = {prio_rd[4*i_addr[3:2]+3], prio_rd[4*i_addr[3:2]+2],
                          prio_rd[4*i_addr[3:2]+1], prio_rd[4*i_addr[3:2]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_dist_drop;
    dist_fall;
  endsequence

  sequence s_cpu_drop;
    cpu_fall;
  endsequence

  a_enable_gate: assert property (sig_ok |-> enable[best_id] && pending[best_id])
    else $error("disabled interrupt selected");
  a_group_gate: assert property (sig_ok |-> dist_en4[best_grp])
    else $error("interrupt of disabled group selected");
  a_cpu_group_mask: assert property (best_found && !cpu_en4[best_grp] |=> !o_irq_valid)
    else $error("cpu disabled group signaled");
  a_lpi_blocked: assert property (!lpi_enable && !lpi_pending |=> !lpi_pending)
    else $error("locality interrupt pended while disabled");
  // the dropped group stays off, so its interrupt cannot come back two edges on
  a_retrieve_seq: assert property (s_dist_drop |=> o_retrieve ##1
                                   (!o_irq_valid || o_irq_group != $past(o_irq_group, 2)))
    else $error("retrieval missing after group disable");
  a_release_seq: assert property (s_cpu_drop |=> o_release ##1
                                  (!o_irq_valid || o_irq_group != $past(o_irq_group, 2)))
    else $error("release missing after cpu group disable");
  a_prio_lowbits: assert property (low_bits_set == '0)
    else $error("unimplemented priority bits set");
  a_mask_check: assert property (o_irq_valid |-> o_irq_prio < $past(pmr))
    else $error("interrupt signaled above mask");
  a_valid_track: assert property (sig_ok |=> o_irq_valid && o_irq_id == $past(best_id))
    else $error("winner not presented");
  for (genvar k = iepsel_pkg::NUM_SGI; k < iepsel_pkg::NUM_IRQ; k++) begin : g_chk
    a_pend_disabled: assert property (rise[k] && !enable[k] |=> pending[k])
      else $error("edge lost on disabled interrupt");
    a_ns_half: assert property (prio_wr_ns[k] |=> prio[k][7])
      else $error("nonsecure priority in upper half");
  end

endmodule : iepsel_top

//--- test/iepsel_cpu_model.sv
// behavioural cpu interface partner that acknowledges presented interrupts
`timescale 1ns/1ps
module iepsel_cpu_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // control from the bench
  input  wire logic        i_en,
  input  wire logic [3:0]  i_dly,
  // presented interrupt
  input  wire logic        i_valid,
  input  wire logic [3:0]  i_id,
  output logic             o_ack,
  output logic      [15:0] o_seq
);
  // -----------------------------------------------------------------
  // acknowledge after a programmable wait
  // -----------------------------------------------------------------
  logic [3:0] wait_cnt;
  logic [1:0] hold;
  // hold off two cycles after an ack, as the valid level lags the clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ack    <= 1'b0;
      o_seq    <= 16'h0000;
      wait_cnt <= 4'h0;
      hold     <= 2'h0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      hold  <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (i_en && i_valid) begin
      if (wait_cnt >= i_dly) begin
        o_ack    <= 1'b1;                  // takes whatever is delivered
        o_seq    <= {o_seq[11:0], i_id};
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : iepsel_cpu_model

//--- test/irq_enable_priority_select_bench.sv
// self-checking bench for the enable gating and priority select block
`timescale 1ns/1ps
module irq_enable_priority_select_bench;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_nonsecure = 1'b0;
  logic [31:0] o_rdata;
  logic [15:4] i_irq_line = 12'h000;
  logic        i_lpi_set = 1'b0;
  logic        i_ack;
  logic        o_irq_valid;
  logic [3:0]  o_irq_id;
  logic [7:0]  o_irq_prio;
  logic [1:0]  o_irq_group;
  logic        o_retrieve;
  logic        o_release;
  logic        pen = 1'b0;
  logic [3:0]  pdly = 4'h0;
  logic [15:0] seq;
  logic        rd_d = 1'b0;
  logic [31:0] seed = 32'h498EE788;
  logic [31:0] expq[$];
  int          n_errors = 0;
  int          compares = 0;
  int          n_ret = 0;
  int          n_rel = 0;

  initial forever #10 i_clk = ~i_clk;

  iepsel_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_nonsecure(i_nonsecure), .o_rdata(o_rdata),
    .i_irq_line(i_irq_line), .i_lpi_set(i_lpi_set), .i_ack(i_ack), .o_irq_valid(o_irq_valid),
    .o_irq_id(o_irq_id), .o_irq_prio(o_irq_prio), .o_irq_group(o_irq_group),
    .o_retrieve(o_retrieve),
    .o_release(o_release));

  iepsel_cpu_model cpu (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(pen), .i_dly(pdly),
    .i_valid(o_irq_valid), .i_id(o_irq_id), .o_ack(i_ack), .o_seq(seq));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic results();
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // one strobe cycle; a read leaves its expectation in the queue
  task automatic bus(input logic w, input logic ns, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_nonsecure <= ns;
    i_addr <= a;
    i_wdata <= d;
    if (!w) expq.push_back(e);
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, 1'b0, a, 32'h0, e);
  endtask : rd

  // selection lands one edge after the state change
  task automatic irq(input logic v, input logic [3:0] id);
    repeat (2) @(posedge i_clk);
    #1 cmp(32'({o_irq_valid, o_irq_id}), 32'({v, id}));
  endtask : irq

  // read data stands only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (rd_d) cmp(o_rdata, expq.pop_front());
    rd_d <= i_rd;
    n_ret <= n_ret + 32'(o_retrieve);
    n_rel <= n_rel + 32'(o_release);
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (4000) @(posedge i_clk);
    n_errors++;
    results();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1 cmp(32'({o_irq_valid, o_irq_prio}), 32'h0FF);
    rd(8'h34, 32'h0);
    wr(8'h00, 32'h7); rd(8'h00, 32'h7);
    wr(8'h24, 32'h7); rd(8'h24, 32'h7);
    wr(8'h04, 32'h0F); wr(8'h08, 32'h04); rd(8'h04, 32'h0B);
    wr(8'h0C, 32'hFF); wr(8'h10, 32'h0F); rd(8'h0C, 32'hF0);
    wr(8'h00, 32'h0); wr(8'h1C, 32'h1); rd(8'h1C, 32'h1);
    wr(8'h20, 32'h1);
    @(posedge i_clk) i_irq_line[11:8] <= 4'hF;
    rd(8'h1C, 32'h0F00);
    wr(8'h48, 32'h10103040);
    wr(8'h28, 32'h80); wr(8'h24, 32'h1); wr(8'h00, 32'h1);
    irq(1'b1, 4'hB);
    rd(8'h2C, 32'h41B);
    wr(8'h04, 32'h04); irq(1'b1, 4'hA);
    wr(8'h00, 32'h0); irq(1'b0, 4'h0);
    cmp(32'(n_ret), 32'h1);
    wr(8'h00, 32'h1); wr(8'h24, 32'h0); irq(1'b0, 4'hA);
    cmp(32'(n_rel), 32'h1);
    wr(8'h24, 32'h1); wr(8'h28, 32'h10); irq(1'b0, 4'hA);
    wr(8'h28, 32'h18); irq(1'b1, 4'hA);
    wr(8'h28, 32'h80);
    seed = lfsr(seed);
    pdly <= seed[3:0];
    pen <= 1'b1;
    repeat (100) @(posedge i_clk);
    #1;
    cmp(32'(seq), 32'hAB98);
    cmp(32'(o_irq_valid), 32'h0);
    // locality interrupts only pend once enabled
    @(posedge i_clk) i_lpi_set <= 1'b1;
    @(posedge i_clk) i_lpi_set <= 1'b0;
    rd(8'h30, 32'h0);
    wr(8'h14, 32'h1);
    @(posedge i_clk) i_lpi_set <= 1'b1;
    @(posedge i_clk) i_lpi_set <= 1'b0;
    rd(8'h30, 32'h1); wr(8'h30, 32'h1); rd(8'h30, 32'h0);
    // width probe on disabled ids, reserved id keeps its fixed value
    wr(8'h4C, 32'hFFFFFFFF); rd(8'h4C, 32'hA0F8F8F8);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(8'h4C, seed);
      rd(8'h4C, (seed & 32'h00F8F8F8) | 32'hA0000000);
    end
    wr(8'h18, 32'h00040000);
    bus(1'b1, 1'b1, 8'h48, 32'h00006200, 32'h0);
    rd(8'h48, 32'h1010B040);
    bus(1'b0, 1'b1, 8'h48, 32'h0, 32'h00006000);
    // nonsecure group one winner while its cpu enable is off: chosen, not signaled
    wr(8'h00, 32'h3); wr(8'h1C, 32'h200); irq(1'b0, 4'h9);
    cmp(32'(o_irq_group), 32'h1);
    repeat (2) @(posedge i_clk);
    results();
  end
endmodule : irq_enable_priority_select_bench
